/* sfsr_dev.sv */
`default_nettype none
module sfsr_dev
  import sfsr_pkg::*;
#(
  parameter int P_PWRUP_CYC = PWRUP_CYC,
  parameter int P_SE_CYC = SE_CYC,
  parameter int P_PP_CYC = PP_CYC,
  parameter int P_RST_CYC = RST_CYC
) (
  input wire logic I_CLK, // System clock, 100 MHz
  input wire logic I_NRST, // Async reset, active low
  input wire logic I_CE, // Clock enable, freezes all state
  sfsr_link_if.dev LINK, // Serial link pins
  input wire logic [SEC_REGS-1:0] I_LOCK_SET, // Pulse: set lock bits for good
  input wire logic [1:0] I_SUSPEND_SET, // Pulse: [0] program, [1] erase suspended
  input wire logic I_VOL_LOAD, // Pulse: load volatile settings
  input wire logic [VOL_W-1:0] I_VOL_DATA, // Volatile settings value
  output logic [STATUS_W-1:0] O_STATUS, // Status word
  output logic [VOL_W-1:0] O_VOL // Volatile settings
);
  typedef struct packed {
    sfsr_dev_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [5:0] bits;
    logic [31:0] shift;
    logic [7:0] op;
    logic [23:0] addr;
    logic [9:0] ofs;
    logic data_seen;
    logic [1:0] sel;
    logic [7:0] obyte;
    logic so;
    logic so_oe;
    logic write_enable_latch;
    logic dpd;
    logic rst_en;
    logic [SEC_REGS-1:0] lock;
    logic sus_p;
    logic sus_e;
    logic drive_strength_bit0;
    logic [VOL_W-1:0] vol;
    logic sclk_d;
    logic cs_d;
    logic [SEC_REGS-1:0][SEC_BYTES-1:0][7:0] mem;
  } sfsr_dev_type;

  sfsr_dev_type s_r;
  sfsr_dev_type s_nxt;
  logic cs_s;
  logic sclk_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  logic fr_one;
  logic sec_gate;

  // Register block decode of a 24-bit address
  function automatic logic addr_ok(input logic [23:0] a);
    addr_ok = (a[23:16] == SEC_HI_BYTE) && (a[11:10] == SEC_GAP_BITS) &&
      (a[15:12] >= SEC_SEL_FIRST) && (a[15:12] <= SEC_SEL_LAST);
  endfunction

  function automatic logic [1:0] reg_idx(input logic [23:0] a);
    reg_idx = 2'(a[15:12] - SEC_SEL_FIRST);
  endfunction

  // Pins are foreign: two flops before use; select idles high
  sfsr_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_ce(I_CE),
    .i_d({LINK.cs_n, LINK.sclk, LINK.si}),
    .o_q({cs_s, sclk_s, si_s})
  );

  // Edges found on the synchronised levels
  assign sclk_rise = sclk_s && !s_r.sclk_d;
  assign sclk_fall = !sclk_s && s_r.sclk_d;
  assign cs_rise = cs_s && !s_r.cs_d;
  assign cs_fall = !cs_s && s_r.cs_d;
  assign fr_one = (s_r.bits == BITS_OPCODE);

  // Shared acceptance test for erase and program
  assign sec_gate = (s_r.st == DST_IDLE) && s_r.write_enable_latch && !s_r.dpd && addr_ok(s_r.addr) &&
    !s_r.lock[reg_idx(s_r.addr)] && !s_r.sus_p;

  always_comb begin
    logic [7:0] rd_byte;
    rd_byte = ERASED_BYTE;
    s_nxt = s_r;
    if (I_CE) begin
      s_nxt.sclk_d = sclk_s;
      s_nxt.cs_d = cs_s;
      // Self-timed cycles, power-up and reset recovery share one counter
      if (s_r.st != DST_IDLE) begin
        if (s_r.cnt == '0) begin
          if (s_r.st == DST_ERASE) begin
            for (int i = 0; i < SEC_BYTES; i++) begin
              s_nxt.mem[s_r.sel][i] = ERASED_BYTE;
            end
          end
          s_nxt.st = DST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      // New frame
      if (cs_fall) begin
        s_nxt.bits = '0;
        s_nxt.op = '0;
        s_nxt.data_seen = 1'b0;
      end
      // Input bits taken on rising serial clock
      if (!cs_s && sclk_rise) begin
        s_nxt.shift = {s_r.shift[30:0], si_s};
        s_nxt.bits = (s_r.bits == BITS_WRAP) ? BITS_DATA0 : s_r.bits + 1'b1;
        if (s_nxt.bits == BITS_OPCODE) begin
          s_nxt.op = s_nxt.shift[7:0];
        end
        if (s_nxt.bits == BITS_ADDR) begin
          s_nxt.addr = s_nxt.shift[23:0];
          s_nxt.ofs = s_nxt.shift[9:0];
        end
        // Flash bits only clear, so each byte is ANDed in as it arrives
        if (s_nxt.bits == BITS_DATA0 && s_r.op == OP_SEC_PROGRAM) begin
          s_nxt.data_seen = 1'b1;
          if (sec_gate) begin
            s_nxt.mem[reg_idx(s_r.addr)][s_r.ofs] =
              s_r.mem[reg_idx(s_r.addr)][s_r.ofs] & s_nxt.shift[7:0];
            s_nxt.ofs = {s_r.ofs[9:8], s_r.ofs[7:0] + 8'h01};
          end
        end
      end
      // Read data driven on falling serial clock
      if (!cs_s && sclk_fall && s_r.op == OP_SEC_READ && s_r.bits >= BITS_DATA0 &&
          s_r.st == DST_IDLE && !s_r.dpd) begin
        s_nxt.so_oe = 1'b1;
        if (s_r.bits == BITS_DATA0) begin
          if (addr_ok(s_r.addr)) begin
            rd_byte = s_r.mem[reg_idx(s_r.addr)][s_r.ofs];
          end
          s_nxt.so = rd_byte[7];
          s_nxt.obyte = {rd_byte[6:0], 1'b0};
          s_nxt.ofs = s_r.ofs + 10'h001;
        end else begin
          s_nxt.so = s_r.obyte[7];
          s_nxt.obyte = {s_r.obyte[6:0], 1'b0};
        end
      end
      if (cs_s) begin
        s_nxt.so_oe = 1'b0;
      end
      // Frame end: execute; nothing taken while powering up or resetting
      if (cs_rise && s_r.st != DST_PWRUP && s_r.st != DST_RESET) begin
        s_nxt.rst_en = fr_one && (s_r.op == OP_RESET_ENABLE);
        if (fr_one && s_r.op == OP_RESET && s_r.rst_en) begin
          s_nxt.st = DST_RESET;
          s_nxt.cnt = CNT_W'(P_RST_CYC - 1);
          s_nxt.write_enable_latch = 1'b0;
          s_nxt.sus_p = 1'b0;
          s_nxt.sus_e = 1'b0;
          s_nxt.dpd = 1'b0;
          s_nxt.vol = '0;
        end else if (s_r.dpd) begin
          if (fr_one && s_r.op == OP_RELEASE_PD) begin
            s_nxt.dpd = 1'b0;
          end
        end else if (s_r.st == DST_IDLE) begin
          if (fr_one && s_r.op == OP_WRITE_ENABLE) begin
            s_nxt.write_enable_latch = 1'b1;
          end
          if (fr_one && s_r.op == OP_POWER_DOWN) begin
            s_nxt.dpd = 1'b1;
          end
          // Erase needs select to rise right after the last address bit
          if (s_r.op == OP_SEC_ERASE && s_r.bits == BITS_ADDR && sec_gate &&
              !s_r.sus_e) begin
            s_nxt.st = DST_ERASE;
            s_nxt.cnt = CNT_W'(P_SE_CYC - 1);
            s_nxt.sel = reg_idx(s_r.addr);
            s_nxt.write_enable_latch = 1'b0;
          end
          if (s_r.op == OP_SEC_PROGRAM && s_r.data_seen && sec_gate) begin
            s_nxt.st = DST_PROG;
            s_nxt.cnt = CNT_W'(P_PP_CYC - 1);
            s_nxt.write_enable_latch = 1'b0;
          end
        end
      end
      // Outside events; a set in the clearing cycle wins
      s_nxt.lock = s_nxt.lock | I_LOCK_SET;
      if (I_SUSPEND_SET[0]) begin
        s_nxt.sus_p = 1'b1;
      end
      if (I_SUSPEND_SET[1]) begin
        s_nxt.sus_e = 1'b1;
      end
      if (I_VOL_LOAD) begin
        s_nxt.vol = I_VOL_DATA;
      end
    end
  end

  // Reset is power-up: erased array, status clear but drive bit set, delay counter loaded
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r <= '0;
      s_r.st <= DST_PWRUP;
      s_r.cnt <= CNT_W'(P_PWRUP_CYC - 1);
      s_r.drive_strength_bit0 <= 1'b1;
      s_r.sclk_d <= 1'b0;
      s_r.cs_d <= 1'b1;
      s_r.mem <= {(SEC_REGS * SEC_BYTES) {ERASED_BYTE}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Status word assembled from flops
  always_comb begin
    O_STATUS = '0;
    O_STATUS[SB_WIP] = (s_r.st == DST_ERASE) || (s_r.st == DST_PROG);
    O_STATUS[SB_WEL] = s_r.write_enable_latch;
    O_STATUS[SB_SUS_E] = s_r.sus_e;
    O_STATUS[SB_LOCK0 +: SEC_REGS] = s_r.lock;
    O_STATUS[SB_SUS_P] = s_r.sus_p;
    O_STATUS[SB_DRIVE_STRENGTH_BIT0] = s_r.drive_strength_bit0;
  end

  assign O_VOL = s_r.vol;
  assign LINK.so = s_r.so;
  assign LINK.so_oe = s_r.so_oe;
endmodule // sfsr_dev
`default_nettype wire

/* sfsr_pkg.sv */
`default_nettype none
package sfsr_pkg;
  // Opcodes seen on the serial input
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_PD = 8'hab;

  // Device frame bit counts; data phase folds back to keep the counter small
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_DATA0 = 6'h28;
  localparam logic [5:0] BITS_WRAP = 6'h2f;

  // Security register address fields and geometry
  localparam logic [7:0] SEC_HI_BYTE = 8'h00;
  localparam logic [1:0] SEC_GAP_BITS = 2'h0;
  localparam logic [3:0] SEC_SEL_FIRST = 4'h1;
  localparam logic [3:0] SEC_SEL_LAST = 4'h3;
  localparam int SEC_REGS = 3;
  localparam int SEC_BYTES = 1024;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int VOL_W = 19;

  // Status word layout
  localparam int STATUS_W = 24;
  localparam int SB_WIP = 0;
  localparam int SB_WEL = 1;
  localparam int SB_SUS_E = 10;
  localparam int SB_LOCK0 = 11;
  localparam int SB_SUS_P = 15;
  localparam int SB_DRIVE_STRENGTH_BIT0 = 21;

  // Timing, figures in their own units
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real T_PWRUP_MS = 1.8;
  localparam real T_SE_MS = 50.0;
  localparam real T_PP_MS = 0.6;
  localparam real T_RST_US = 30.0;
  localparam int PWRUP_CYC = int'($ceil(T_PWRUP_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int SE_CYC = int'($ceil(T_SE_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int PP_CYC = int'($ceil(T_PP_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int RST_CYC = int'($ceil(T_RST_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int CNT_W = 24;

  // Host serial clock: eight system cycles per half period
  localparam logic [2:0] SCLK_HALF_LAST = 3'h7;
  localparam logic [6:0] HBITS_BYTE = 7'h08;
  localparam logic [6:0] HBITS_ADDR = 7'h18;

  // Host register map and fields
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_ADDR = 8'h04;
  localparam logic [7:0] HREG_WDATA = 8'h08;
  localparam logic [7:0] HREG_STATUS = 8'h0c;
  localparam int CMD_ADDR_BIT = 8;
  localparam int CMD_DUMMY_BIT = 9;
  localparam int CMD_WDATA_BIT = 10;
  localparam int CMD_RDATA_BIT = 11;
  localparam int CMD_W = 12;
  localparam int HS_BUSY_BIT = 0;
  localparam int HS_REFUSED_BIT = 1;
  localparam int HS_RX_LSB = 8;

  typedef enum logic [2:0] {DST_PWRUP, DST_IDLE, DST_ERASE, DST_PROG, DST_RESET}
    sfsr_dev_state_type;
  typedef enum logic [1:0] {HST_IDLE, HST_SHIFT, HST_END, HST_GAP} sfsr_host_state_type;
endpackage
`default_nettype wire

/* sfsr_link_if.sv */
`default_nettype none
interface sfsr_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input cs_n, input sclk, input si, output so, output so_oe);
  modport host (output cs_n, output sclk, output si, input so, input so_oe);
endinterface
`default_nettype wire

/* sfsr_sync.sv */
`default_nettype none
module sfsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk, // System clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [W-1:0] i_d, // Foreign-domain levels
  output logic [W-1:0] o_q // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sfsr_sync_type;
  sfsr_sync_type s_r;
  sfsr_sync_type s_nxt;

  // First stage feeds only the second
  always_comb begin
    s_nxt = s_r;
    if (i_ce) begin
      s_nxt.meta = i_d;
      s_nxt.q = s_r.meta;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= {RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.q;
endmodule // sfsr_sync
`default_nettype wire

/* sfsr_host.sv */
`default_nettype none
module sfsr_host
  import sfsr_pkg::*;
(
  input wire logic I_CLK, // System clock, 100 MHz
  input wire logic I_NRST, // Async reset, active low
  input wire logic I_CE, // Clock enable, freezes all state
  sfsr_link_if.host LINK, // Serial link pins
  input wire logic I_DEV_BUSY, // Flash busy or suspended, foreign level
  input wire logic [7:0] I_WB_ADR, // Wishbone byte address
  input wire logic [31:0] I_WB_DAT, // Wishbone write data
  input wire logic [3:0] I_WB_SEL, // Wishbone byte selects
  input wire logic I_WB_WE, // Wishbone write
  input wire logic I_WB_CYC, // Wishbone cycle
  input wire logic I_WB_STB, // Wishbone strobe
  output logic O_WB_ACK, // Wishbone acknowledge
  output logic [31:0] O_WB_DAT // Wishbone read data
);
  typedef struct packed {
    sfsr_host_state_type st;
    logic [2:0] div;
    logic [6:0] bits;
    logic [63:0] tx;
    logic [7:0] rx;
    logic sclk;
    logic cs_n;
    logic si;
    logic [CMD_W-1:0] cmd;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic refused;
    logic ack;
    logic [31:0] dat;
  } sfsr_host_type;

  sfsr_host_type s_r;
  sfsr_host_type s_nxt;
  logic so_s;
  logic busy_s;
  logic wb_req;

  // Returned data and busy come from outside this clock
  sfsr_sync #(.W(2), .RST_VAL(2'h0)) u_sync (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_ce(I_CE),
    .i_d({LINK.so, I_DEV_BUSY}),
    .o_q({so_s, busy_s})
  );

  assign wb_req = I_WB_CYC && I_WB_STB && !s_r.ack;

  always_comb begin
    logic [7:0] op;
    op = I_WB_DAT[7:0];
    s_nxt = s_r;
    if (I_CE) begin
      // Bus slave: one wait state, ack for one cycle
      s_nxt.ack = wb_req;
      if (wb_req && !I_WB_WE) begin
        case (I_WB_ADR)
          HREG_CMD: s_nxt.dat = 32'(s_r.cmd);
          HREG_ADDR: s_nxt.dat = 32'(s_r.addr);
          HREG_WDATA: s_nxt.dat = 32'(s_r.wdata);
          HREG_STATUS: begin
            s_nxt.dat = '0;
            s_nxt.dat[HS_BUSY_BIT] = (s_r.st != HST_IDLE);
            s_nxt.dat[HS_REFUSED_BIT] = s_r.refused;
            s_nxt.dat[HS_RX_LSB +: 8] = s_r.rx;
          end
          default: s_nxt.dat = '0;
        endcase
      end
      if (wb_req && I_WB_WE && (I_WB_SEL != '0)) begin
        case (I_WB_ADR)
          HREG_ADDR: s_nxt.addr = I_WB_DAT[23:0];
          HREG_WDATA: s_nxt.wdata = I_WB_DAT[7:0];
          HREG_CMD: begin
            // Each command is its own frame; reset pair refused while flash busy
            if (s_r.st != HST_IDLE || (busy_s &&
                (op == OP_RESET_ENABLE || op == OP_RESET))) begin
              s_nxt.refused = 1'b1;
            end else begin
              s_nxt.refused = 1'b0;
              s_nxt.cmd = I_WB_DAT[CMD_W-1:0];
              s_nxt.tx = {op, s_r.addr, I_WB_DAT[CMD_WDATA_BIT] ? s_r.wdata : 8'h00,
                24'h000000};
              s_nxt.bits = HBITS_BYTE + (I_WB_DAT[CMD_ADDR_BIT] ? HBITS_ADDR : 7'h00) +
                ((I_WB_DAT[CMD_DUMMY_BIT] || I_WB_DAT[CMD_WDATA_BIT]) ? HBITS_BYTE : 7'h00) +
                (I_WB_DAT[CMD_RDATA_BIT] ? HBITS_BYTE : 7'h00);
              s_nxt.si = op[7];
              s_nxt.tx = {s_nxt.tx[62:0], 1'b0};
              s_nxt.cs_n = 1'b0;
              s_nxt.sclk = 1'b0;
              s_nxt.div = '0;
              s_nxt.st = HST_SHIFT;
            end
          end
          default: ;
        endcase
      end
      // Serial engine: data changes on falling, sampled on rising
      case (s_r.st)
        HST_IDLE: ;
        HST_SHIFT: begin
          s_nxt.div = s_r.div + 3'h1;
          if (s_r.div == SCLK_HALF_LAST) begin
            if (!s_r.sclk) begin
              s_nxt.sclk = 1'b1;
              s_nxt.rx = {s_r.rx[6:0], so_s};
              s_nxt.bits = s_r.bits - 7'h01;
            end else begin
              s_nxt.sclk = 1'b0;
              if (s_r.bits == '0) begin
                s_nxt.st = HST_END;
              end else begin
                s_nxt.si = s_r.tx[63];
                s_nxt.tx = {s_r.tx[62:0], 1'b0};
              end
            end
          end
        end
        HST_END: begin
          s_nxt.div = s_r.div + 3'h1;
          if (s_r.div == SCLK_HALF_LAST) begin
            s_nxt.cs_n = 1'b1;
            s_nxt.si = 1'b0;
            s_nxt.st = HST_GAP;
          end
        end
        HST_GAP: begin
          // Select stays high at least half a clock between frames
          s_nxt.div = s_r.div + 3'h1;
          if (s_r.div == SCLK_HALF_LAST) begin
            s_nxt.st = HST_IDLE;
          end
        end
        default: s_nxt.st = HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r <= '0;
      s_r.st <= HST_IDLE;
      s_r.cs_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LINK.cs_n = s_r.cs_n;
  assign LINK.sclk = s_r.sclk;
  assign LINK.si = s_r.si;
  assign O_WB_ACK = s_r.ack;
  assign O_WB_DAT = s_r.dat;
endmodule // sfsr_host
`default_nettype wire

/* sfsr_props.sv */
`default_nettype none
module sfsr_props
  import sfsr_pkg::*;
#(
  parameter int P_SE_CYC = 40,
  parameter int P_PP_CYC = 30
) (
  input wire logic I_CLK, // System clock
  input wire logic I_NRST, // Async reset, active low
  input wire logic cs_n, // Select
  input wire logic sclk, // Serial clock
  input wire logic si, // Host data
  input wire logic so, // Device data
  input wire logic so_oe, // Device drive enable
  input wire logic [STATUS_W-1:0] O_STATUS // Device status
);
  // Program is the shortest cycle, erase the longest
  localparam int WIP_MIN = P_PP_CYC - 4;
  localparam int WIP_MAX = P_SE_CYC + 4;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // Wire framing
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock moved while deselected");
  chk_si_held_high: assert property (sclk && $past(sclk) |-> $stable(si))
    else $error("input data changed while clock high");
  chk_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sclk)
    else $error("output data changed while clock high");
  chk_oe_released: assert property (cs_n [*5] |-> !so_oe)
    else $error("output driven while deselected");
  // Self-timed cycles
  chk_wip_after_cs: assert property ($rose(O_STATUS[SB_WIP]) |-> cs_n && $past(cs_n, 2))
    else $error("busy rose without a select rise");
  chk_wel_cleared: assert property ($rose(O_STATUS[SB_WIP]) |-> ##[0:2] !O_STATUS[SB_WEL])
    else $error("latch not cleared by cycle start");
  chk_wip_holds: assert property ($rose(O_STATUS[SB_WIP]) |-> O_STATUS[SB_WIP] [*8])
    else $error("busy dropped too early");
  chk_wip_ends: assert property ($rose(O_STATUS[SB_WIP]) |->
    ##[WIP_MIN:WIP_MAX] !O_STATUS[SB_WIP])
    else $error("busy did not end in time");
  // Locks never fall; drive bit stays at its default
  chk_lock_kept: assert property (!$fell(O_STATUS[SB_LOCK0]) && !$fell(O_STATUS[SB_LOCK0 + 1])
    && !$fell(O_STATUS[SB_LOCK0 + 2]))
    else $error("lock bit cleared");
  chk_drive_bit: assert property (O_STATUS[SB_DRIVE_STRENGTH_BIT0])
    else $error("drive strength bit not set");
endmodule // sfsr_props
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top
  import sfsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SE = 40;
  localparam int PP = 30;
  logic clk, nrst, ce, ovr, vol_ld, wb_we, wb_cyc, wb_stb, ack;
  logic [2:0] lock_set;
  logic [1:0] sus_set;
  logic [VOL_W-1:0] vol_d, vol_q;
  logic [STATUS_W-1:0] st;
  logic [7:0] wb_adr;
  logic [31:0] wb_wd, rd, rnd, hs;
  logic [7:0] mem [3][1024];
  logic [9:0] offs [3];
  int n_fail, n_checks;
  sfsr_link_if lnk ();

  sfsr_dev #(.P_PWRUP_CYC(50), .P_SE_CYC(SE), .P_PP_CYC(PP), .P_RST_CYC(20)) sfsr_dev_i (
    .I_CLK(clk), .I_NRST(nrst), .I_CE(ce), .LINK(lnk), .I_LOCK_SET(lock_set),
    .I_SUSPEND_SET(sus_set), .I_VOL_LOAD(vol_ld), .I_VOL_DATA(vol_d), .O_STATUS(st),
    .O_VOL(vol_q));
  // Host blocks reset while busy or suspended, unless the bench overrides it
  sfsr_host sfsr_host_i (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce), .LINK(lnk),
    .I_DEV_BUSY((st[SB_WIP] | st[SB_SUS_E] | st[SB_SUS_P]) & !ovr), .I_WB_ADR(wb_adr),
    .I_WB_DAT(wb_wd), .I_WB_SEL(4'hf), .I_WB_WE(wb_we), .I_WB_CYC(wb_cyc),
    .I_WB_STB(wb_stb), .O_WB_ACK(ack), .O_WB_DAT(rd));
  sfsr_props #(.P_SE_CYC(SE), .P_PP_CYC(PP)) sfsr_props_i (.I_CLK(clk), .I_NRST(nrst),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe),
    .O_STATUS(st));

  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [23:0] sa(input int r, input int off);
    return {8'h00, 4'(r), 2'b00, 10'(off)};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; waits on ack, never on a fixed count
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_adr <= a;
    wb_we <= we;
    wb_wd <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (k >= 100) n_fail++;
    hs = rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Whole frame: load, launch, wait for host and then for the device cycle
  task automatic fr(input logic [11:0] c, input logic [23:0] a, input logic [7:0] d);
    int k;
    wb(HREG_ADDR, 1'b1, {8'h00, a});
    wb(HREG_WDATA, 1'b1, {24'h0, d});
    wb(HREG_CMD, 1'b1, {20'h0, c});
    k = 0;
    do begin
      wb(HREG_STATUS, 1'b0, 32'h0);
      k++;
    end while (hs[HS_BUSY_BIT] !== 1'b0 && k < 400);
    repeat (8) @(posedge clk);
    while (st[SB_WIP] !== 1'b0 && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) n_fail++;
  endtask

  task automatic rdc(input int r, input int off);
    fr(12'hb00 | OP_SEC_READ, sa(r, off), 8'h00);
    chk(hs[15:8], mem[r-1][off]);
  endtask

  task automatic pulse_in(input logic [2:0] lk, input logic [1:0] su, input logic vl);
    @(posedge clk);
    lock_set <= lk;
    sus_set <= su;
    vol_ld <= vl;
    @(posedge clk);
    lock_set <= 3'h0;
    sus_set <= 2'h0;
    vol_ld <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #500000;
    n_fail++;
    summarize;
  end

  // Main sequence
  initial begin
    {nrst, ovr, vol_ld, lock_set, sus_set, vol_d, wb_adr, wb_we, wb_wd, wb_cyc, wb_stb} = '0;
    ce = 1'b1;
    n_fail = 0;
    n_checks = 0;
    rnd = 32'hc4e1;
    foreach (mem[i, j]) mem[i][j] = ERASED_BYTE;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(st, 32'h200000);
    repeat (60) @(posedge clk);
    rdc(3, 1023);
    fr(12'h500 | OP_SEC_PROGRAM, sa(1, 5), 8'h12);
    rdc(1, 5);
    $display("test defaults and latch done");
    for (int r = 1; r <= 3; r++) begin
      rnd = lfsr(rnd);
      offs[r-1] = (r == 3) ? 10'h3ff : rnd[9:0];
      fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
      chk(st[SB_WEL], 1);
      fr(12'h500 | OP_SEC_PROGRAM, sa(r, offs[r-1]), rnd[17:10]);
      mem[r-1][offs[r-1]] &= rnd[17:10];
      chk(st[SB_WEL], 0);
      rdc(r, offs[r-1]);
      rdc(r % 3 + 1, offs[r-1]);
    end
    $display("test program done");
    fr(12'(OP_POWER_DOWN), 24'h0, 8'h00);
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    chk(st[SB_WEL], 0);
    fr(12'(OP_RELEASE_PD), 24'h0, 8'h00);
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    chk(st[SB_WEL], 1);
    fr(12'h500 | OP_SEC_PROGRAM, 24'h001400, 8'h00);
    rdc(1, 0);
    fr(12'hb00 | OP_SEC_READ, 24'h004000, 8'h00);
    chk(hs[15:8], 8'hff);
    $display("test power-down and decode done");
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    fr(12'h500 | OP_SEC_ERASE, sa(1, 0), 8'h00);
    rdc(1, offs[0]);
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    fr(12'h100 | OP_SEC_ERASE, sa(2, rnd[25:16]), 8'h00);
    for (int j = 0; j < SEC_BYTES; j++) mem[1][j] = ERASED_BYTE;
    rdc(2, offs[1]);
    rdc(1, offs[0]);
    pulse_in(3'b001, 2'b00, 1'b0);
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    fr(12'h100 | OP_SEC_ERASE, sa(1, 0), 8'h00);
    rdc(1, offs[0]);
    $display("test erase and lock done");
    vol_d <= rnd[18:0] | 19'h1;
    pulse_in(3'b000, 2'b01, 1'b1);
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    fr(12'h500 | OP_SEC_PROGRAM, sa(3, offs[2]), 8'h00);
    rdc(3, offs[2]);
    fr(12'(OP_RESET_ENABLE), 24'h0, 8'h00);
    chk(hs[HS_REFUSED_BIT], 1);
    ovr <= 1'b1;
    fr(12'(OP_RESET_ENABLE), 24'h0, 8'h00);
    fr(12'(OP_WRITE_ENABLE), 24'h0, 8'h00);
    fr(12'(OP_RESET), 24'h0, 8'h00);
    chk(vol_q, rnd[18:0] | 19'h1);
    fr(12'(OP_RESET_ENABLE), 24'h0, 8'h00);
    fr(12'(OP_RESET), 24'h0, 8'h00);
    repeat (30) @(posedge clk);
    chk(vol_q, 0);
    chk(st, 32'h200800);
    $display("test reset done");
    summarize;
  end
endmodule // tb_top
`default_nettype wire
